// File: core/bam_pkg.sv
/*
 * Constants, types and address decoding shared by the byte-addressed
 * MODBUS setpoint map and its CRC helper.
 * Assumes a byte-wide receiver and transmitter on the same clock.
 */
package bam_pkg;

	// Function codes and exception codes
	localparam logic [7:0] FC_READ        = 8'h03;
	localparam logic [7:0] FC_WRITE       = 8'h06;
	localparam logic [7:0] EXC_FLAG       = 8'h80;
	localparam logic [7:0] EXC_ILL_FUNC   = 8'h01;
	localparam logic [7:0] EXC_ILL_ADDR   = 8'h02;
	localparam logic [7:0] EXC_ILL_VALUE  = 8'h03;

	// Frame layout
	localparam logic [3:0]  REQ_LEN       = 4'h8;
	localparam logic [7:0]  HDR_LEN       = 8'h03;
	localparam logic [7:0]  ECHO_LEN      = 8'h06;
	localparam logic [15:0] MAX_WORDS     = 16'h007D;
	localparam logic [16:0] MAP_END       = 17'h0_0100;
	localparam int          MEM_BYTES     = 256;

	// Frame check word
	localparam logic [15:0] CRC_INIT      = 16'hFFFF;
	localparam logic [15:0] CRC_POLY      = 16'hA001;
	localparam logic [15:0] CRC_RESIDUE   = 16'h0000;

	// Two-byte writable variables
	localparam logic [7:0] LOCK_MASK_ADDR = 8'hD3;
	localparam logic [7:0] HIGH_KW_ADDR   = 8'hD7;
	localparam logic [7:0] LOW_KW_ADDR    = 8'hDD;
	localparam logic [7:0] LOW_V_ADDR     = 8'hE6;
	localparam logic [7:0] HIGH_V_ADDR    = 8'hE8;

	// Writable windows and fixed bytes
	localparam logic [7:0] CMD_ADDR       = 8'h64;
	localparam logic [7:0] SP_FIRST       = 8'hD3;
	localparam logic [7:0] SP_LAST        = 8'hFB;
	localparam logic [7:0] DEV_ADDR_BYTE  = 8'hFB;
	localparam logic [7:0] OC_ADDR        = 8'hEC;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_TX} bam_state_t;
	typedef enum logic [1:0] {RSP_READ, RSP_ECHO, RSP_EXC} bam_resp_t;

	// Address names a 16-bit writable variable
	function automatic logic bam_is_wide(input logic [7:0] a);
		return (a == LOCK_MASK_ADDR) || (a == HIGH_KW_ADDR) || (a == LOW_KW_ADDR) ||
			(a == LOW_V_ADDR) || (a == HIGH_V_ADDR);
	endfunction

	// Address is the second byte of a 16-bit variable
	function automatic logic bam_is_mid(input logic [7:0] a);
		return bam_is_wide(a - 8'h01);
	endfunction

endpackage

// File: core/bam_crc_byte.sv
/*
 * One-byte step of the MODBUS frame check word (reflected 0xA001).
 * Purely combinational; caller holds the running value.
 */
`timescale 1ns/10ps
module bam_crc_byte import bam_pkg::*; (
	input  wire logic [15:0] crc_in,
	input  wire logic [7:0]  data_in,
	output logic      [15:0] crc_out
);

	// Eight shift steps, LSB first as on the wire
	always_comb begin
		logic [15:0] c;
		c = crc_in ^ {8'h00, data_in};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		crc_out = c;
	end

endmodule // bam_crc_byte

// File: core/bam_setpoint_map.sv
/*
 * Slave-side register access of a motor protection relay: byte-addressed
 * map served by MODBUS read (03) and single write (06) frames.
 * Assumes framing logic delivers received bytes and a frame_end pulse
 * after the inter-frame gap, and takes bytes out with valid/ready.
 */
// Contract
// - Read returns two bytes per word, consecutive
// - One-byte write leaves neighbour byte untouched
// - Read at overcurrent gives overcurrent then undercurrent
// - Write decodes address for one or two bytes
// - Only five addresses accept sixteen-bit writes
// - Write inside two-byte variable refused; read allowed
// - Nonvolatile writes limited; write only changed values
// - Reads never consume nonvolatile write endurance
// - Multi-word reads pack two bytes per word
// - Lower address byte is word high half
// - Eleven words from low voltage give setpoints
// - Address, count and data go high byte first
// - Check word goes low byte first
// - Successful write echoes the request bytes
// - Bad check word: frame dropped, not executed
`timescale 1ns/10ps
module bam_setpoint_map import bam_pkg::*; (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	input  wire logic       frame_end,
	output logic            tx_valid,
	output logic      [7:0] tx_data,
	input  wire logic       tx_ready,
	input  wire logic       upd_we,
	input  wire logic [7:0] upd_addr,
	input  wire logic [7:0] upd_data,
	output logic            nv_wr,
	output logic      [7:0] nv_addr,
	output logic     [15:0] nv_data,
	output logic            nv_wide
);

	bam_state_t  st_q;
	bam_resp_t   kind_q;
	logic [7:0]  mem_q [MEM_BYTES];
	logic [7:0]  rx_buf_q [REQ_LEN];
	logic [3:0]  rx_cnt_q;
	logic [15:0] rx_crc_q;
	logic [15:0] rx_crc_nxt;
	logic [15:0] tx_crc_q;
	logic [15:0] tx_crc_nxt;
	logic [7:0]  tx_data_q;
	logic        tx_valid_q;
	logic [7:0]  tx_idx_q;
	logic [7:0]  tx_plen_q;
	logic [7:0]  rd_base_q;
	logic [7:0]  exc_q;
	logic        nv_wr_q;
	logic [7:0]  nv_addr_q;
	logic [15:0] nv_data_q;
	logic        nv_wide_q;

	// Receive side: bytes are only taken while idle, the link is half duplex
	wire rx_take = rx_valid && (st_q == ST_IDLE);

	bam_crc_byte u_rx_crc (
		.crc_in  (rx_crc_q),
		.data_in (rx_data),
		.crc_out (rx_crc_nxt)
	);

	// Byte counter saturates so longer frames never look like requests
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_cnt_q <= 4'h0;
			rx_crc_q <= CRC_INIT;
		end else if ((st_q == ST_IDLE) && frame_end) begin
			rx_cnt_q <= 4'h0;
			rx_crc_q <= CRC_INIT;
		end else if (rx_take) begin
			rx_cnt_q <= (rx_cnt_q == 4'hF) ? rx_cnt_q : rx_cnt_q + 4'h1;
			rx_crc_q <= rx_crc_nxt;
		end
	end

	// Request bytes held until the reply is out, for decode and echo
	always_ff @(posedge clk) begin
		if (rx_take && (rx_cnt_q < REQ_LEN)) begin
			rx_buf_q[rx_cnt_q[2:0]] <= rx_data;
		end
	end

	// Request fields, high byte first on the wire
	wire [7:0]  req_fc   = rx_buf_q[1];
	wire [15:0] req_addr = {rx_buf_q[2], rx_buf_q[3]};
	wire [15:0] req_val  = {rx_buf_q[4], rx_buf_q[5]};
	wire [7:0]  tgt      = req_addr[7:0];
	wire [7:0]  tgt_nb   = tgt + 8'h01;

	// Running check over all eight bytes leaves zero when the frame is intact
	wire frame_ok = (rx_cnt_q == REQ_LEN) && (rx_crc_q == CRC_RESIDUE) &&
		(rx_buf_q[0] == mem_q[DEV_ADDR_BYTE]);

	// Read legality: whole reply must stay inside the byte map
	wire [16:0] rd_end   = {1'b0, req_addr} + {req_val, 1'b0};
	wire        rd_cnt_ok = (req_val != 16'h0000) && (req_val <= MAX_WORDS);
	wire        rd_adr_ok = (rd_end <= MAP_END);

	// Write legality and width, decided by address alone
	wire wr_in_map = (req_addr[15:8] == 8'h00) &&
		((tgt == CMD_ADDR) || ((tgt >= SP_FIRST) && (tgt <= SP_LAST)));
	wire wr_adr_ok = wr_in_map && !bam_is_mid(tgt);
	wire wr_wide   = bam_is_wide(tgt);

	// Response selection and exception code
	wire is_rd = (req_fc == FC_READ);
	wire is_wr = (req_fc == FC_WRITE);
	wire [7:0] exc_code = (!is_rd && !is_wr) ? EXC_ILL_FUNC :
		(is_rd && !rd_cnt_ok) ? EXC_ILL_VALUE : EXC_ILL_ADDR;
	wire rsp_ok = (is_rd && rd_cnt_ok && rd_adr_ok) || (is_wr && wr_adr_ok);
	bam_resp_t resp_sel;
	assign resp_sel = !rsp_ok ? RSP_EXC : (is_rd ? RSP_READ : RSP_ECHO);
	wire [7:0] plen_d = (resp_sel == RSP_READ) ? HDR_LEN + {req_val[6:0], 1'b0} :
		(resp_sel == RSP_ECHO) ? ECHO_LEN : HDR_LEN;

	// Write commit happens only for an accepted 06 frame
	wire exec_wr = (st_q == ST_EXEC) && (resp_sel == RSP_ECHO);
	wire wr_changed = wr_wide ? ({mem_q[tgt], mem_q[tgt_nb]} != req_val) :
		(mem_q[tgt] != req_val[7:0]);

	// Byte map; a frame write wins and a live update in that cycle is lost
	always_ff @(posedge clk) begin
		if (exec_wr) begin
			if (wr_wide) begin
				mem_q[tgt]    <= req_val[15:8];
				mem_q[tgt_nb] <= req_val[7:0];
			end else begin
				mem_q[tgt]    <= req_val[7:0];
			end
		end else if (upd_we) begin
			mem_q[upd_addr] <= upd_data;
		end
	end

	// Transmit side byte selection for the next index
	wire [7:0] nidx   = tx_idx_q + 8'h01;
	wire [7:0] rd_ptr = rd_base_q + nidx - HDR_LEN;
	wire [7:0] pay_byte =
		(nidx == 8'h01) ? ((kind_q == RSP_EXC) ? (req_fc | EXC_FLAG) : req_fc) :
		(nidx == 8'h02) ? ((kind_q == RSP_READ) ? {req_val[6:0], 1'b0} :
			(kind_q == RSP_EXC) ? exc_q : rx_buf_q[2]) :
		(kind_q == RSP_READ) ? mem_q[rd_ptr] : rx_buf_q[nidx[2:0]];
	wire [7:0] next_byte = (nidx < tx_plen_q) ? pay_byte :
		(nidx == tx_plen_q) ? tx_crc_nxt[7:0] : tx_crc_q[15:8];

	bam_crc_byte u_tx_crc (
		.crc_in  (tx_crc_q),
		.data_in (tx_data_q),
		.crc_out (tx_crc_nxt)
	);

	// Control: idle, one decode cycle, then stream the reply
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q       <= ST_IDLE;
			kind_q     <= RSP_EXC;
			tx_valid_q <= 1'b0;
			tx_data_q  <= 8'h00;
			tx_idx_q   <= 8'h00;
			tx_plen_q  <= 8'h00;
			tx_crc_q   <= CRC_INIT;
			rd_base_q  <= 8'h00;
			exc_q      <= 8'h00;
			nv_wr_q    <= 1'b0;
			nv_addr_q  <= 8'h00;
			nv_data_q  <= 16'h0000;
			nv_wide_q  <= 1'b0;
		end else begin
			nv_wr_q <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					if (frame_end && frame_ok) begin
						st_q <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					kind_q     <= resp_sel;
					exc_q      <= exc_code;
					rd_base_q  <= tgt;
					tx_plen_q  <= plen_d;
					tx_idx_q   <= 8'h00;
					tx_crc_q   <= CRC_INIT;
					tx_data_q  <= rx_buf_q[0];
					tx_valid_q <= 1'b1;
					st_q       <= ST_TX;
					// Unchanged values skip the storage write to save endurance
					if (exec_wr && wr_changed) begin
						nv_wr_q   <= 1'b1;
						nv_addr_q <= tgt;
						nv_data_q <= wr_wide ? req_val : {8'h00, req_val[7:0]};
						nv_wide_q <= wr_wide;
					end
				end
				ST_TX: begin
					if (tx_ready) begin
						tx_idx_q <= nidx;
						if (tx_idx_q < tx_plen_q) begin
							tx_crc_q <= tx_crc_nxt;
						end
						if (tx_idx_q == tx_plen_q + 8'h01) begin
							tx_valid_q <= 1'b0;
							st_q       <= ST_IDLE;
						end else begin
							tx_data_q <= next_byte;
						end
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	assign tx_valid = tx_valid_q;
	assign tx_data  = tx_data_q;
	assign nv_wr    = nv_wr_q;
	assign nv_addr  = nv_addr_q;
	assign nv_data  = nv_data_q;
	assign nv_wide  = nv_wide_q;

	// Helper: neighbour byte as it stood one cycle earlier
	logic [7:0] nb_old_q;
	always_ff @(posedge clk) begin
		nb_old_q <= mem_q[tgt_nb];
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Frame acceptance, write width, map bytes and reply order
	property p_bad_frame;
		(st_q == ST_IDLE) && frame_end && !frame_ok |=> (st_q == ST_IDLE) && !tx_valid;
	endproperty
	a_bad_frame: assert property (p_bad_frame) else $error("bad frame executed");
	property p_refuse_mid;
		(st_q == ST_EXEC) && is_wr && bam_is_mid(tgt) |-> !exec_wr ##1 exc_q == EXC_ILL_ADDR;
	endproperty
	a_refuse_mid: assert property (p_refuse_mid) else $error("mid-word write accepted");
	property p_exc_no_store;
		(st_q == ST_EXEC) && (resp_sel == RSP_EXC) |=> !nv_wr && (kind_q == RSP_EXC);
	endproperty
	a_exc_no_store: assert property (p_exc_no_store) else $error("refused write stored");
	property p_single_byte;
		exec_wr && !wr_wide |=> (mem_q[tgt] == $past(req_val[7:0])) && (mem_q[tgt_nb] == nb_old_q);
	endproperty
	a_single_byte: assert property (p_single_byte) else $error("neighbour byte changed");
	property p_wide_write;
		exec_wr && wr_wide |=> (mem_q[tgt] == $past(req_val[15:8])) &&
			(mem_q[tgt_nb] == $past(req_val[7:0]));
	endproperty
	a_wide_write: assert property (p_wide_write) else $error("wide write wrong order");
	property p_read_no_nv;
		(st_q == ST_EXEC) && (resp_sel == RSP_READ) |=> !nv_wr ##1 !nv_wr;
	endproperty
	a_read_no_nv: assert property (p_read_no_nv) else $error("read caused storage write");
	property p_byte_count;
		tx_valid && (kind_q == RSP_READ) && (tx_idx_q == 8'h02) |->
			(tx_data == {rx_buf_q[5][6:0], 1'b0}) && (tx_plen_q == tx_data + HDR_LEN);
	endproperty
	a_byte_count: assert property (p_byte_count) else $error("byte count wrong");
	property p_read_data;
		tx_valid && (kind_q == RSP_READ) && (tx_idx_q >= HDR_LEN) && (tx_idx_q < tx_plen_q) |->
			tx_data == mem_q[rd_base_q + tx_idx_q - HDR_LEN];
	endproperty
	a_read_data: assert property (p_read_data) else $error("read byte not from map");
	property p_echo;
		tx_valid && (kind_q == RSP_ECHO) && (tx_idx_q < ECHO_LEN) |->
			tx_data == rx_buf_q[tx_idx_q[2:0]];
	endproperty
	a_echo: assert property (p_echo) else $error("echo byte differs");
	property p_crc_lo;
		tx_valid && (tx_idx_q == tx_plen_q) |-> tx_data == tx_crc_q[7:0];
	endproperty
	a_crc_lo: assert property (p_crc_lo) else $error("check low byte wrong");
	property p_crc_hi;
		tx_valid && tx_ready && (tx_idx_q == tx_plen_q) |=>
			tx_valid && (tx_data == tx_crc_q[15:8]);
	endproperty
	a_crc_hi: assert property (p_crc_hi) else $error("check high byte wrong");

	// Last byte of a reply taken by the transmitter
	wire tx_last = tx_valid && tx_ready && (tx_idx_q == tx_plen_q + 8'h01);
	c_read: cover property (tx_last && (kind_q == RSP_READ));
	c_echo: cover property (tx_last && (kind_q == RSP_ECHO));
	c_exc:  cover property ((st_q == ST_EXEC) && is_wr && bam_is_mid(tgt));
	c_oc:   cover property ((st_q == ST_EXEC) && is_rd && (tgt == OC_ADDR));

endmodule // bam_setpoint_map

// File: tb/bam_master_model.sv
/*
 * Master-side model of the request and reply links: sends whole frames
 * and gathers the reply bytes. Assumes it shares clk with the slave.
 */
`timescale 1ns/10ps
module bam_master_model import bam_pkg::*; (
	input  wire logic       clk,
	output logic            rx_valid,
	output logic      [7:0] rx_data,
	output logic            frame_end,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	logic slow = 1'b0;

	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		frame_end = 1'b0;
		tx_ready = 1'b0;
	end

	// Slow mode drops ready every other cycle, as a busy transmitter would
	always @(posedge clk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end

	// Frame check word over a byte list, reflected polynomial
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	// Bytes back to back, then the gap; the idle line shows inverted data
	task automatic send(input logic [7:0] f[$]);
		foreach (f[i]) begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_data  <= f[i];
		end
		@(posedge clk);
		rx_valid  <= 1'b0;
		rx_data   <= ~rx_data;
		frame_end <= 1'b1;
		@(posedge clk);
		frame_end <= 1'b0;
	endtask

	// Take bytes until the line goes idle; empty if nothing comes in time
	task automatic get_reply(output logic [7:0] r[$], input int bound);
		r = {};
		for (int n = 0; n < bound; n++) begin
			@(posedge clk);
			if (tx_valid && tx_ready) r.push_back(tx_data);
			else if (r.size() > 0 && !tx_valid) break;
		end
	endtask
endmodule // bam_master_model

// File: tb/bam_setpoint_map_bench.sv
/*
 * Self-checking bench for the setpoint map: loads the byte map, then runs
 * reads, writes, refusals and a corrupted frame through the master model.
 * Assumes the device address byte is loaded before the first request.
 */
`timescale 1ns/10ps
module bam_setpoint_map_bench import bam_pkg::*;;
	localparam logic [7:0] DEV = 8'h01;
	logic        clk, rst, upd_we, rx_valid, frame_end, tx_valid, tx_ready, nv_wr, nv_wide;
	logic [7:0]  upd_addr, upd_data, rx_data, tx_data, nv_addr;
	logic [15:0] nv_data;
	logic [7:0]  mem [256];
	logic [7:0]  wl [5] = '{LOCK_MASK_ADDR, HIGH_KW_ADDR, LOW_KW_ADDR, LOW_V_ADDR, HIGH_V_ADDR};
	int          fail_count = 0;
	int          checks_done = 0;
	int          nv_cnt = 0;

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	bam_setpoint_map u_dut (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
		.frame_end(frame_end), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.upd_we(upd_we), .upd_addr(upd_addr), .upd_data(upd_data), .nv_wr(nv_wr),
		.nv_addr(nv_addr), .nv_data(nv_data), .nv_wide(nv_wide));

	bam_master_model u_mst (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.frame_end(frame_end), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

	// Storage write pulses, counted so suppressed writes show up
	always @(posedge clk) begin
		if (nv_wr === 1'b1) nv_cnt <= nv_cnt + 1;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		if (fail_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	function automatic bit wide_at(input logic [7:0] a);
		return a inside {LOCK_MASK_ADDR, HIGH_KW_ADDR, LOW_KW_ADDR, LOW_V_ADDR, HIGH_V_ADDR};
	endfunction

	// One request and its reply; bad spoils the check word, silence expected
	task automatic xfer(input logic [7:0] fc, input logic [7:0] a, input logic [15:0] v,
			input logic [7:0] e[$], input bit bad);
		logic [7:0]  f[$];
		logic [7:0]  r[$];
		logic [15:0] c;
		f = {DEV, fc, 8'h00, a, v[15:8], v[7:0]};
		c = u_mst.crc16(f);
		f.push_back(c[7:0] ^ {7'h00, bad});
		f.push_back(c[15:8]);
		if (e.size() > 0) begin
			c = u_mst.crc16(e);
			e.push_back(c[7:0]);
			e.push_back(c[15:8]);
		end
		u_mst.send(f);
		u_mst.get_reply(r, 120);
		chk(16'(r.size()), 16'(e.size()));
		if (r.size() != e.size()) final_report();
		foreach (e[i]) chk({8'h00, r[i]}, {8'h00, e[i]});
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] n);
		logic [7:0] e[$];
		int         n0;
		n0 = nv_cnt;
		e = {DEV, FC_READ, 8'(2 * n)};
		for (int i = 0; i < 2 * n; i++) e.push_back(mem[8'(a + i)]);
		xfer(FC_READ, a, {8'h00, n}, e, 1'b0);
		chk(16'(nv_cnt - n0), 16'h0000);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] v, input bit bad);
		logic [7:0] e[$];
		bit         ok;
		bit         chg;
		int         n0;
		n0 = nv_cnt;
		ok = (a == CMD_ADDR || (a >= SP_FIRST && a <= SP_LAST)) && !wide_at(a - 8'h01);
		chg = wide_at(a) ? ({mem[a], mem[8'(a + 1)]} != v) : (mem[a] != v[7:0]);
		e = {DEV, FC_WRITE, 8'h00, a, v[15:8], v[7:0]};
		if (!ok) e = {DEV, FC_WRITE | EXC_FLAG, EXC_ILL_ADDR};
		if (bad) e = {};
		xfer(FC_WRITE, a, v, e, bad);
		if (ok && !bad) begin
			if (wide_at(a)) mem[8'(a + 1)] = v[7:0];
			mem[a] = wide_at(a) ? v[15:8] : v[7:0];
		end
		chk(16'(nv_cnt - n0), {15'h0000, ok && !bad && chg});
		if (ok && !bad && chg) begin
			chk({7'h00, nv_wide, nv_addr}, {7'h00, wide_at(a), a});
			chk(nv_data, wide_at(a) ? v : {8'h00, v[7:0]});
		end
	endtask

	// Refused request: only the exception reply comes back, storage untouched
	task automatic exc(input logic [7:0] fc, input logic [7:0] a, input logic [15:0] v,
			input logic [7:0] code);
		logic [7:0] e[$];
		int         n0;
		n0 = nv_cnt;
		e = {DEV, fc | EXC_FLAG, code};
		xfer(fc, a, v, e, 1'b0);
		chk(16'(nv_cnt - n0), 16'h0000);
	endtask

	initial begin
		rst = 1'b1;
		upd_we = 1'b0;
		upd_addr = 8'h00;
		upd_data = 8'h00;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		// Distinct pattern everywhere except the device address byte, so a wrong byte position cannot hide
		for (int i = 0; i < 256; i++) begin
			@(posedge clk);
			mem[i] = (8'(i) == DEV_ADDR_BYTE) ? DEV : 8'(i * 7 + 3);
			upd_we <= 1'b1;
			upd_addr <= 8'(i);
			upd_data <= mem[i];
		end
		@(posedge clk);
		upd_we <= 1'b0;
		repeat (2) @(posedge clk);
		rd(OC_ADDR, 8'h01);
		rd(8'h2B, 8'h0F);
		u_mst.slow = 1'b1;
		rd(LOW_V_ADDR, 8'h0B);
		u_mst.slow = 1'b0;
		wr(8'hED, 16'h0019, 1'b0);
		rd(OC_ADDR, 8'h01);
		wr(8'hED, 16'h0019, 1'b0);
		foreach (wl[k]) begin
			wr(wl[k], {wl[k], ~wl[k]}, 1'b0);
			wr(8'(wl[k] + 1), 16'h5555, 1'b0);
		end
		rd(8'hE7, 8'h01);
		wr(CMD_ADDR, 16'h00DD, 1'b0);
		wr(8'h10, 16'h0001, 1'b0);
		exc(8'h04, 8'h00, 16'h0001, EXC_ILL_FUNC);
		exc(FC_READ, 8'h00, 16'h0000, EXC_ILL_VALUE);
		exc(FC_READ, 8'hFF, 16'h0001, EXC_ILL_ADDR);
		wr(8'hEC, 16'h0077, 1'b1);
		rd(LOW_V_ADDR, 8'h0B);
		final_report();
	end
endmodule // bam_setpoint_map_bench
